// *** hdl/flash_config_field_loader.v ***
// Reset-time configuration field loader with the array read port inside.
// Assumes sys_resetn_i is the chip reset, held low by others until hold_reset_o drops.
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg_regs.vh"

module flash_config_field_loader (
  // Clock and block reset
  input wire clk_sys_i,
  input wire rstn_i,
  // System reset sequence
  input wire sys_resetn_i,
  output reg hold_reset_o,
  output reg cfg_done_o,
  // Start-up conditions
  input wire special_mode_i,
  input wire watchdog_reset_i,
  // Command controller status
  input wire cmd_busy_i,
  // Captured configuration
  output reg [63:0] unlock_key_o,
  output reg [7:0] protection_byte_reg_o,
  output reg [7:0] flash_option_byte_reg_o,
  output reg [7:0] security_byte_reg_o,
  output reg secured_o,
  // Watchdog start-up settings and service check
  output reg [2:0] watchdog_rate_select_o,
  output reg window_watchdog_enable_o,
  output reg watchdog_enabled_o,
  output reg [4:0] watchdog_timeout_log2_o,
  input wire [15:0] watchdog_count_i,
  input wire watchdog_service_i,
  output reg early_service_reset_o,
  // Bus reads
  input wire bus_req_i,
  input wire bus_info_i,
  input wire bus_word_i,
  input wire [15:0] bus_addr_i,
  output wire bus_ready_o,
  output wire bus_err_o,
  output wire [15:0] bus_rdata_o,
  output wire [5:0] bus_sector_o,
  output wire [1:0] bus_region_o,
  // Array macro
  output wire mem_rd_o,
  output wire mem_info_o,
  output wire [13:0] mem_waddr_o,
  input wire [15:0] mem_rdata_i
);

  localparam L_ISSUE = 2'h0;
  localparam L_WAIT = 2'h1;
  localparam L_DONE = 2'h2;

  reg [1:0] lstate; // Loader state
  reg [2:0] widx; // Field word being read
  reg ld_req; // Read request pulse to the port
  reg sys_resetn_q; // Last sample of system reset
  wire ld_valid; // Port answer to the loader
  wire [15:0] ld_data; // Word returned to the loader

  // Timeout exponent for a rate code
  function [4:0] rate_log2;
    input [2:0] r;
    begin
      case (r)
        3'h1: rate_log2 = 5'h06;
        3'h2: rate_log2 = 5'h08;
        3'h3: rate_log2 = 5'h0A;
        3'h4: rate_log2 = 5'h0C;
        3'h5: rate_log2 = 5'h0E;
        3'h6: rate_log2 = 5'h0F;
        3'h7: rate_log2 = 5'h10;
        default: rate_log2 = 5'h00;
      endcase
    end
  endfunction

  // Start of the service window: three quarters of the timeout
  wire [16:0] window_start = {14'h0000, 3'h3} << (watchdog_timeout_log2_o - 5'h02);

  ////////////////////////////////////////////////////////////////////////////
  // Array read port, shared between loader and bus
  flash_read_port u_port (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .blocked_i(cmd_busy_i),
    .ld_req_i(ld_req),
    .ld_addr_i(`CFG_BASE + {11'h000, widx, 1'b0}),
    .ld_valid_o(ld_valid),
    .ld_data_o(ld_data),
    .bus_req_i(bus_req_i && cfg_done_o),
    .bus_info_i(bus_info_i),
    .bus_word_i(bus_word_i),
    .bus_addr_i(bus_addr_i),
    .bus_ready_o(bus_ready_o),
    .bus_err_o(bus_err_o),
    .bus_rdata_o(bus_rdata_o),
    .bus_sector_o(bus_sector_o),
    .bus_region_o(bus_region_o),
    .mem_rd_o(mem_rd_o),
    .mem_info_o(mem_info_o),
    .mem_waddr_o(mem_waddr_o),
    .mem_rdata_i(mem_rdata_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Loader: walks the eight field words while the system is in reset.
  // Bus reads are shut out until the field is in; a read still in the port when a reload starts can make the port miss ld_req.
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      lstate <= L_ISSUE;
      widx <= 3'h0;
      ld_req <= 1'b0;
      sys_resetn_q <= 1'b0;
      cfg_done_o <= 1'b0;
      hold_reset_o <= 1'b1;
      unlock_key_o <= {4{`ERASED_WORD}};
      protection_byte_reg_o <= `ERASED_BYTE;
      flash_option_byte_reg_o <= `ERASED_BYTE;
      security_byte_reg_o <= `ERASED_BYTE;
      secured_o <= 1'b1;
    end else begin
      sys_resetn_q <= sys_resetn_i;
      ld_req <= 1'b0;
      if (!sys_resetn_i && sys_resetn_q) begin
        // New reset sequence: read the field again
        lstate <= L_ISSUE;
        widx <= 3'h0;
        cfg_done_o <= 1'b0;
        hold_reset_o <= 1'b1;
      end else begin
        case (lstate)
          L_ISSUE: begin
            ld_req <= 1'b1;
            lstate <= L_WAIT;
          end
          L_WAIT: begin
            if (ld_valid) begin
              // Key words first, then protection, option and security
              if (widx <= `CFG_KEY_LAST_WORD) begin
                unlock_key_o[{~widx[1:0], 4'h0} +: 16] <= ld_data;
              end else if (widx == `CFG_PROT_WORD) begin
                protection_byte_reg_o <= ld_data[7:0];
              end else if (widx == `CFG_OPT_SEC_WORD) begin
                flash_option_byte_reg_o <= ld_data[15:8];
                security_byte_reg_o <= ld_data[7:0];
                secured_o <= ld_data[`SEC_HI:`SEC_LO] != `SEC_UNSECURED;
              end
              if (widx == `CFG_LAST_WORD) begin
                lstate <= L_DONE;
                cfg_done_o <= 1'b1;
                hold_reset_o <= 1'b0;
              end else begin
                widx <= widx + 3'h1;
                lstate <= L_ISSUE;
              end
            end
          end
          default: begin
            // Field held stable until the next reset sequence
            lstate <= L_DONE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog start-up settings, taken on the rising edge of system reset
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      watchdog_rate_select_o <= `RATE_OFF;
      window_watchdog_enable_o <= 1'b0;
      watchdog_enabled_o <= 1'b0;
      watchdog_timeout_log2_o <= 5'h00;
    end else if (sys_resetn_i && !sys_resetn_q) begin
      if (secured_o && special_mode_i && watchdog_reset_i) begin
        watchdog_rate_select_o <= `RATE_LONGEST;
        watchdog_enabled_o <= 1'b1;
        watchdog_timeout_log2_o <= rate_log2(`RATE_LONGEST);
      end else begin
        watchdog_rate_select_o <= ~flash_option_byte_reg_o[`OPT_RATE_HI:`OPT_RATE_LO];
        watchdog_enabled_o <= ~flash_option_byte_reg_o[`OPT_RATE_HI:`OPT_RATE_LO] != `RATE_OFF;
        watchdog_timeout_log2_o <= rate_log2(~flash_option_byte_reg_o[`OPT_RATE_HI:`OPT_RATE_LO]);
      end
      window_watchdog_enable_o <= ~flash_option_byte_reg_o[`OPT_WIN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Early service check: a service write before the last quarter resets the part
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      early_service_reset_o <= 1'b0;
    end else begin
      early_service_reset_o <= watchdog_service_i && watchdog_enabled_o &&
        window_watchdog_enable_o && ({1'b0, watchdog_count_i} < window_start);
    end
  end

endmodule // flash_config_field_loader

`default_nettype wire

// *** hdl/flash_cfg_regs.vh ***
// Constants for the configuration field loader and its array read port.
// Assumes a 32 kbyte array with a 16-bit word-wide read macro, big-endian bytes.
`ifndef FLASH_CFG_REGS_VH
`define FLASH_CFG_REGS_VH

// Address map (byte offsets from the array or info memory base)
`define ARRAY_LAST 16'h7FFF
`define INFO_LAST 16'h007F
`define CFG_BASE 15'h7F00
`define CFG_LAST_WORD 3'h7
`define CFG_KEY_LAST_WORD 3'h3
`define CFG_PROT_WORD 3'h6
`define CFG_OPT_SEC_WORD 3'h7

// Sector index field of a byte address (64 sectors of 512 bytes)
`define SECTOR_HI 14
`define SECTOR_LO 9

// Info memory region bounds and codes
`define INFO_WAFER_LAST 7'h0D
`define INFO_CTRL_FIRST 7'h40
`define INFO_CTRL_LAST 7'h4F
`define INFO_MCU_FIRST 7'h7C
`define REGION_WAFER 2'h0
`define REGION_CTRL 2'h1
`define REGION_MCU 2'h2
`define REGION_RSVD 2'h3

// Option byte fields and watchdog codes
`define OPT_RATE_HI 2
`define OPT_RATE_LO 0
`define OPT_WIN_BIT 3
`define RATE_OFF 3'h0
`define RATE_LONGEST 3'h7
`define SEC_HI 1
`define SEC_LO 0
`define SEC_UNSECURED 2'h2

// Read values and reset values
`define ERASED_WORD 16'hFFFF
`define ERASED_BYTE 8'hFF
`define ZERO_BYTE 8'h00

`endif

// *** hdl/flash_read_port.v ***
// Read port of the nonvolatile array: decode, latency and command blocking.
// Assumes the array macro answers mem_rdata_i in the same cycle as its address.
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg_regs.vh"

module flash_read_port (
  // Clock and reset
  input wire clk_sys_i,
  input wire rstn_i,
  // Command controller status
  input wire blocked_i,
  // Loader requests (word-aligned byte address)
  input wire ld_req_i,
  input wire [14:0] ld_addr_i,
  output reg ld_valid_o,
  output reg [15:0] ld_data_o,
  // Bus read requests
  input wire bus_req_i,
  input wire bus_info_i,
  input wire bus_word_i,
  input wire [15:0] bus_addr_i,
  output reg bus_ready_o,
  output reg bus_err_o,
  output reg [15:0] bus_rdata_o,
  output reg [5:0] bus_sector_o,
  output reg [1:0] bus_region_o,
  // Array macro
  output reg mem_rd_o,
  output reg mem_info_o,
  output reg [13:0] mem_waddr_o,
  input wire [15:0] mem_rdata_i
);

  localparam S_IDLE = 2'h0;
  localparam S_HOLD = 2'h1;
  localparam S_FIRST = 2'h2;
  localparam S_SECOND = 2'h3;

  reg [1:0] state; // Access sequencer
  reg p_ld; // Pending access is the loader's
  reg p_word; // Pending access is a word
  reg p_odd; // Pending address is odd
  reg [7:0] hi_byte; // First half of a misaligned word

  // Info memory region of an address
  function [1:0] info_region;
    input [6:0] a;
    begin
      if (a <= `INFO_WAFER_LAST) begin
        info_region = `REGION_WAFER;
      end else if (a >= `INFO_CTRL_FIRST && a <= `INFO_CTRL_LAST) begin
        info_region = `REGION_CTRL;
      end else if (a >= `INFO_MCU_FIRST) begin
        info_region = `REGION_MCU;
      end else begin
        info_region = `REGION_RSVD;
      end
    end
  endfunction

  // Address in range for its space
  wire bus_hit = bus_info_i ? (bus_addr_i <= `INFO_LAST) : (bus_addr_i <= `ARRAY_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one cycle for bytes and aligned words, two for misaligned words
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state <= S_IDLE;
      p_ld <= 1'b0;
      p_word <= 1'b0;
      p_odd <= 1'b0;
      hi_byte <= `ZERO_BYTE;
      ld_valid_o <= 1'b0;
      ld_data_o <= `ERASED_WORD;
      bus_ready_o <= 1'b0;
      bus_err_o <= 1'b0;
      bus_rdata_o <= `ERASED_WORD;
      bus_sector_o <= 6'h00;
      bus_region_o <= `REGION_WAFER;
      mem_rd_o <= 1'b0;
      mem_info_o <= 1'b0;
      mem_waddr_o <= 14'h0000;
    end else begin
      // Answers are single-cycle pulses
      ld_valid_o <= 1'b0;
      bus_ready_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (ld_req_i) begin
            // Loader first: it only runs while the system is held in reset
            p_ld <= 1'b1;
            p_word <= 1'b1;
            p_odd <= 1'b0;
            mem_info_o <= 1'b0;
            mem_waddr_o <= ld_addr_i[14:1];
            mem_rd_o <= !blocked_i;
            state <= blocked_i ? S_HOLD : S_FIRST;
          end else if (bus_req_i && !bus_hit) begin
            // Unmapped: answer at once with erased data and an error
            bus_ready_o <= 1'b1;
            bus_err_o <= 1'b1;
            bus_rdata_o <= `ERASED_WORD;
          end else if (bus_req_i) begin
            p_ld <= 1'b0;
            p_word <= bus_word_i;
            p_odd <= bus_addr_i[0];
            mem_info_o <= bus_info_i;
            mem_waddr_o <= bus_addr_i[14:1];
            bus_sector_o <= bus_addr_i[`SECTOR_HI:`SECTOR_LO];
            bus_region_o <= info_region(bus_addr_i[6:0]);
            mem_rd_o <= !blocked_i;
            state <= blocked_i ? S_HOLD : S_FIRST;
          end
        end
        S_HOLD: begin
          // Wait out a running program or erase command
          if (!blocked_i) begin
            mem_rd_o <= 1'b1;
            state <= S_FIRST;
          end
        end
        S_FIRST: begin
          if (p_ld) begin
            ld_valid_o <= 1'b1;
            ld_data_o <= mem_rdata_i;
            mem_rd_o <= 1'b0;
            state <= S_IDLE;
          end else if (p_word && p_odd) begin
            // Misaligned word: high byte is the low half of this word
            hi_byte <= mem_rdata_i[7:0];
            mem_waddr_o <= mem_waddr_o + 14'h0001;
            state <= S_SECOND;
          end else begin
            bus_ready_o <= 1'b1;
            bus_err_o <= 1'b0;
            if (p_word) begin
              bus_rdata_o <= mem_rdata_i;
            end else if (p_odd) begin
              bus_rdata_o <= {`ZERO_BYTE, mem_rdata_i[7:0]};
            end else begin
              bus_rdata_o <= {`ZERO_BYTE, mem_rdata_i[15:8]};
            end
            mem_rd_o <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: begin
          // Second half; a command that starts in between stalls it
          if (!blocked_i) begin
            bus_ready_o <= 1'b1;
            bus_err_o <= 1'b0;
            bus_rdata_o <= {hi_byte, mem_rdata_i[15:8]};
            mem_rd_o <= 1'b0;
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

endmodule // flash_read_port

`default_nettype wire

// *** bench/flash_array_model.sv ***
// Behavioural array macro: word wide, big-endian, answers in the address cycle.
// Assumes the bench sets the option and security bytes before each load.
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  // Clock
  input wire logic clk_sys_i,
  // Field contents chosen by the bench
  input wire logic [7:0] opt_i,
  input wire logic [7:0] sec_i,
  // Macro side
  input wire logic mem_rd_i,
  input wire logic mem_info_i,
  input wire logic [13:0] mem_waddr_i,
  output logic [15:0] mem_rdata_o
);
  logic [15:0] last = 16'h0000; // Last word shown, inverted when idle
  ////////////////////////////////////////////////////////////////////////////////
  // Byte contents; the model is read-only and never programs a cell
  function automatic logic [7:0] byte_at(input logic info, input logic [15:0] a);
    if (info) return {1'b0, a[6:0]} ^ 8'h5A; // Info memory pattern
    if (a[14:3] == 12'hFE0) return 8'hC0 + a[7:0]; // Key bytes
    if (a[14:0] == 15'h7F0D) return 8'h3D; // Protection byte
    if (a[14:0] == 15'h7F0E) return opt_i; // Option byte
    if (a[14:0] == 15'h7F0F) return sec_i; // Security byte
    if (a[14:13] == 2'h0) return a[7:0] ^ 8'h3C; // Programmed low area
    return 8'hFF; // Erased cells read all ones
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus shows the inverse so a stale sample cannot pass for data
  always_comb begin
    mem_rdata_o = ~last;
    if (mem_rd_i) mem_rdata_o = {byte_at(mem_info_i, {1'b0, mem_waddr_i, 1'b0}),
      byte_at(mem_info_i, {1'b0, mem_waddr_i, 1'b1})};
  end
  always_ff @(posedge clk_sys_i) begin
    if (mem_rd_i) last <= mem_rdata_o;
  end
endmodule // flash_array_model
`default_nettype wire

// *** bench/flash_config_field_loader_asserts.sv ***
// Timing checks on the loader's ports: read latency, decode, watchdog load.
// Assumes one clock domain and that requests come only while the port is idle.
`timescale 1ns/100ps
`default_nettype none
module flash_config_field_loader_asserts (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Reset sequence and start-up
  input wire logic sys_resetn_i,
  input wire logic hold_reset_o,
  input wire logic cfg_done_o,
  input wire logic special_mode_i,
  input wire logic watchdog_reset_i,
  input wire logic cmd_busy_i,
  input wire logic secured_o,
  input wire logic [7:0] flash_option_byte_reg_o,
  // Watchdog settings
  input wire logic [2:0] watchdog_rate_select_o,
  input wire logic window_watchdog_enable_o,
  input wire logic watchdog_enabled_o,
  // Bus reads
  input wire logic bus_req_i,
  input wire logic bus_info_i,
  input wire logic bus_word_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_ready_o,
  input wire logic bus_err_o,
  input wire logic [15:0] bus_rdata_o,
  input wire logic [5:0] bus_sector_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic mapped; // Address inside the selected space
  logic [5:0] sector_in; // Sector field of the request
  logic [3:0] opt_low; // Rate and window option bits
  assign mapped = bus_info_i ? (bus_addr_i <= 16'h007F) : (bus_addr_i <= 16'h7FFF);
  assign sector_in = bus_addr_i[14:9];
  assign opt_low = flash_option_byte_reg_o[3:0];
  ////////////////////////////////////////////////////////////////////////////////
  // Accepted request and reset-rise events
  sequence go_s;
    bus_req_i && cfg_done_o && !bus_ready_o;
  endsequence
  sequence rise_s;
    $rose(sys_resetn_i);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_ready_pulse: assert property (bus_ready_o |=> !bus_ready_o)
    else $error("ready held longer than one cycle");
  chk_byte_time: assert property (go_s ##0 (mapped && !(bus_word_i && bus_addr_i[0])
    && !cmd_busy_i) ##1 (!cmd_busy_i)[*2] |-> bus_ready_o)
    else $error("byte or aligned word not answered in time");
  chk_split_time: assert property (go_s ##0 (mapped && bus_word_i && bus_addr_i[0])
    ##0 (!cmd_busy_i)[*4] |-> bus_ready_o && !$past(bus_ready_o))
    else $error("misaligned word latency wrong");
  chk_busy_stall: assert property (go_s ##0 mapped ##0 cmd_busy_i[*3] |=> !bus_ready_o)
    else $error("read answered while a command runs");
  chk_unmapped_err: assert property (go_s ##0 !mapped |=> bus_ready_o && bus_err_o
    && bus_rdata_o == 16'hFFFF)
    else $error("unmapped read not refused");
  chk_sector_field: assert property (go_s ##0 (mapped && !bus_info_i)
    |=> bus_sector_o == $past(sector_in))
    else $error("sector index wrong");
  chk_done_hold: assert property (hold_reset_o == !cfg_done_o)
    else $error("hold and done disagree");
  chk_load_rise: assert property (rise_s ##0 !(secured_o && special_mode_i && watchdog_reset_i)
    |=> {window_watchdog_enable_o, watchdog_rate_select_o} == ~$past(opt_low))
    else $error("watchdog settings not loaded from option byte");
  chk_secure_force: assert property (rise_s ##0 (secured_o && special_mode_i
    && watchdog_reset_i) |=> watchdog_rate_select_o == 3'h7)
    else $error("secured special start did not force longest rate");
  chk_rate_hold: assert property (!$rose(sys_resetn_i) |=> $stable(watchdog_rate_select_o))
    else $error("rate changed away from reset rise");
  chk_wdog_off: assert property (watchdog_enabled_o == (watchdog_rate_select_o != 3'h0))
    else $error("watchdog enable does not follow rate");
endmodule // flash_config_field_loader_asserts
`default_nettype wire

// *** bench/flash_config_field_loader_bench.sv ***
// Self-checking bench: field loads over all option codes, then a read table.
// Assumes the array model answers in the address cycle; one 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module flash_config_field_loader_bench;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, sys_resetn_i = 1'b0, special_mode_i = 1'b0;
  logic watchdog_reset_i = 1'b0, cmd_busy_i = 1'b0, watchdog_service_i = 1'b0;
  logic bus_req_i = 1'b0, bus_info_i = 1'b0, bus_word_i = 1'b0;
  logic [15:0] watchdog_count_i = 16'h0000, bus_addr_i = 16'h0000;
  logic [7:0] opt_v = 8'hFF, sec_v = 8'hFE; // Field bytes served by the model
  logic hold_reset_o, cfg_done_o, secured_o, window_watchdog_enable_o, watchdog_enabled_o;
  logic early_service_reset_o, bus_ready_o, bus_err_o, mem_rd_o, mem_info_o;
  logic [63:0] unlock_key_o;
  logic [7:0] protection_byte_reg_o, flash_option_byte_reg_o, security_byte_reg_o;
  logic [2:0] watchdog_rate_select_o;
  logic [4:0] watchdog_timeout_log2_o;
  logic [15:0] bus_rdata_o, mem_rdata_i;
  logic [5:0] bus_sector_o;
  logic [1:0] bus_region_o;
  logic [13:0] mem_waddr_o;
  int errors = 0, n_checks = 0, cycles = 0, i;
  // Read table rows: info, word, byte offset; boundaries on both spaces
  localparam logic [17:0] ROWS [13] = '{18'h00010, 18'h10010, 18'h10011, 18'h14000,
    18'h07FFF, 18'h08000, 18'h17F0E, 18'h2007F, 18'h20080, 18'h20045, 18'h3000C,
    18'h20020, 18'h30041};
  ////////////////////////////////////////////////////////////////////////////////
  flash_config_field_loader dut (.*);
  flash_array_model am (.clk_sys_i(clk_sys_i), .opt_i(opt_v), .sec_i(sec_v),
    .mem_rd_i(mem_rd_o), .mem_info_i(mem_info_o), .mem_waddr_i(mem_waddr_o),
    .mem_rdata_o(mem_rdata_i));
  always #50 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // Hang guard; the whole run needs well under two thousand cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Restart the field load, check captures, then release and check watchdog
  task automatic load(input logic [7:0] opt, sec, input logic spec, wd);
    logic [2:0] r;
    logic [4:0] lg;
    int n;
    @(posedge clk_sys_i);
    sys_resetn_i <= 1'b0;
    opt_v <= opt;
    sec_v <= sec;
    special_mode_i <= spec;
    watchdog_reset_i <= wd;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(hold_reset_o === 1'b1, "hold missing during load");
    for (n = 0; n < 60 && cfg_done_o !== 1'b1; n++) @(posedge clk_sys_i);
    #1;
    chk(flash_option_byte_reg_o === opt && protection_byte_reg_o === 8'h3D, "opt/prot");
    chk(security_byte_reg_o === sec && unlock_key_o === 64'hC0C1C2C3C4C5C6C7, "sec/key");
    chk(secured_o === (sec[1:0] != 2'h2) && hold_reset_o === 1'b0, "secured/hold");
    @(posedge clk_sys_i);
    sys_resetn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    r = (sec[1:0] != 2'h2 && spec && wd) ? 3'h7 : ~opt[2:0];
    lg = (r == 3'h0) ? 5'h00 : (r < 3'h6) ? {r, 1'b0} + 5'h04 : r + 5'h09;
    chk(watchdog_rate_select_o === r && window_watchdog_enable_o === ~opt[3], "rate");
    chk(watchdog_enabled_o === (r != 3'h0) && watchdog_timeout_log2_o === lg, "timeout");
  endtask
  // One bus read with expectations worked out from the address map
  task automatic rd(input logic info, word, input logic [15:0] a, input logic stall);
    logic [15:0] exp;
    logic err;
    logic [1:0] rg;
    int n;
    err = info ? a > 16'h007F : a > 16'h7FFF;
    exp = {am.byte_at(info, a), am.byte_at(info, a + 16'h0001)};
    if (!word) exp = {8'h00, exp[15:8]};
    if (err) exp = 16'hFFFF;
    rg = (a <= 16'h000D) ? 2'h0 : (a >= 16'h0040 && a <= 16'h004F) ? 2'h1 :
      (a >= 16'h007C) ? 2'h2 : 2'h3;
    @(posedge clk_sys_i);
    bus_info_i <= info;
    bus_word_i <= word;
    bus_addr_i <= a;
    bus_req_i <= 1'b1;
    @(posedge clk_sys_i);
    bus_req_i <= 1'b0;
    // Let the request edge settle; n then counts edges after the taking edge
    #1;
    for (n = 0; n < 30 && bus_ready_o !== 1'b1; n++) begin
      @(posedge clk_sys_i);
      if (stall && n == 3) cmd_busy_i <= 1'b0;
      #1;
      if (stall && n < 3) chk(mem_rd_o === 1'b0, "array read while busy");
    end
    chk(bus_rdata_o === exp, "read data");
    chk(bus_err_o === err, "error flag");
    chk(stall ? n > 4 : n == (err ? 0 : (word && a[0]) ? 2 : 1), "latency");
    if (!err && !info) chk(bus_sector_o === a[14:9], "sector");
    if (!err && info) chk(bus_region_o === rg, "region");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic seen;
    repeat (5) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    #1;
    chk(hold_reset_o === 1'b1 && cfg_done_o === 1'b0 && bus_ready_o === 1'b0, "reset");
    for (i = 0; i < 16; i++) load(i[7:0], 8'hFE, 1'b1, 1'b1);
    load(8'h07, 8'h00, 1'b1, 1'b1);
    load(8'h07, 8'h00, 1'b0, 1'b1);
    load(8'h06, 8'hFE, 1'b0, 1'b0);
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys_i);
      watchdog_count_i <= i ? 16'h003C : 16'h000A;
      watchdog_service_i <= 1'b1;
      @(posedge clk_sys_i);
      watchdog_service_i <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
        #1;
        seen = seen | (early_service_reset_o === 1'b1);
        @(posedge clk_sys_i);
      end
      chk(seen === (i == 0), "early service");
    end
    for (i = 0; i < 13; i++) rd(ROWS[i][17], ROWS[i][16], ROWS[i][15:0], 1'b0);
    @(posedge clk_sys_i);
    cmd_busy_i <= 1'b1;
    rd(1'b0, 1'b1, 16'h0011, 1'b1);
    final_report();
  end
endmodule // flash_config_field_loader_bench
bind flash_config_field_loader flash_config_field_loader_asserts chk_i (.*);
`default_nettype wire
